// ===== hdl/sram_host.sv
// host controller driving a 256K x 16 asynchronous static memory
// Functional notes
// - host holds write data 25 ns before and 0 ns after write end
// - read data valid by 45 ns; host keeps read cycles 45 ns or more
// - host gives 35 ns address setup, 35 ns pulses, 45 ns write cycle
// - host keeps address stable from write start until after write end
// - host holds written lane byte selects low 35 ns before write end
// - host keeps write strobe high through every read
// - host never toggles byte selects while deselected
// - host does not drive data while memory may drive it
// - host presents address no later than selects fall
`timescale 1ns/1ns
module sram_host (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // user request side
  input  wire logic                              req_valid,
  input  wire logic                              req_write,
  input  wire logic [sram_host_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [sram_host_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [sram_host_pkg::BE_W-1:0]    req_be,
  output logic                                   req_ready,
  output logic                                   rsp_valid,
  output logic      [sram_host_pkg::DATA_W-1:0]  rsp_rdata,
  // memory pins
  output logic      [sram_host_pkg::ADDR_W-1:0]  mem_addr,
  output logic                                   chip_sel_n,
  output logic                                   write_en_n,
  output logic                                   out_en_n,
  output logic                                   upper_byte_sel_n,
  output logic                                   lower_byte_sel_n,
  output logic      [sram_host_pkg::DATA_W-1:0]  mem_dq_o,
  output logic                                   mem_dq_oe,
  input  wire logic [sram_host_pkg::DATA_W-1:0]  mem_dq_i
);

  // ---------------------------------------------------------------
  // state and pin registers
  // ---------------------------------------------------------------
  sram_host_pkg::host_state_t              st_q,    st_d;
  logic [sram_host_pkg::CNT_W-1:0]         cnt_q,   cnt_d;
  logic [sram_host_pkg::ADDR_W-1:0]        addr_q,  addr_d;
  logic [sram_host_pkg::DATA_W-1:0]        wdat_q,  wdat_d;
  logic [sram_host_pkg::BE_W-1:0]          be_q,    be_d;
  logic                                    cs_n_q,  cs_n_d;
  logic                                    we_n_q,  we_n_d;
  logic                                    oe_n_q,  oe_n_d;
  logic                                    ub_n_q,  ub_n_d;
  logic                                    lb_n_q,  lb_n_d;
  logic                                    dqoe_q,  dqoe_d;
  logic                                    rdy_q,   rdy_d;
  logic                                    rv_q,    rv_d;
  logic [sram_host_pkg::DATA_W-1:0]        rdat_q,  rdat_d;
  logic [sram_host_pkg::DATA_W-1:0]        dq_sync;

  // pin data crosses from the memory's timing into clk
  sram_bus_sync #(
    .W (sram_host_pkg::DATA_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (mem_dq_i),
    .sync_out (dq_sync)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // one access at a time; request taken only in idle with ready high
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    be_d   = be_q;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    ub_n_d = ub_n_q;
    lb_n_d = lb_n_q;
    dqoe_d = dqoe_q;
    rdy_d  = rdy_q;
    rv_d   = 1'b0;
    rdat_d = rdat_q;
    case (st_q)
      sram_host_pkg::ST_IDLE: begin
        if (req_valid && rdy_q && (req_be != '0)) begin
          rdy_d  = 1'b0;
          addr_d = req_addr;                 // address leads the selects by a cycle in writes, moves with them in reads
          wdat_d = req_wdata;
          be_d   = req_be;
          if (req_write) begin
            st_d   = sram_host_pkg::ST_WR_SETUP;
            oe_n_d = 1'b1;                   // memory floats, host may drive
            dqoe_d = 1'b0;
          end else begin
            st_d   = sram_host_pkg::ST_RD;
            cnt_d  = sram_host_pkg::RD_CYC;
            cs_n_d = 1'b0;
            we_n_d = 1'b1;                   // strobe stays high in reads
            oe_n_d = 1'b0;
            ub_n_d = ~req_be[1];             // only requested lanes
            lb_n_d = ~req_be[0];
          end
        end
      end
      sram_host_pkg::ST_RD: begin
        // hold address and controls for the full access plus sync delay
        if (cnt_q == 4'h1) begin
          rv_d   = 1'b1;
          rdat_d = dq_sync;
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
          ub_n_d = 1'b1;                     // lane selects only move together with chip select
          lb_n_d = 1'b1;
          cnt_d  = sram_host_pkg::TURN_CYC;
          st_d   = sram_host_pkg::ST_TURN;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      sram_host_pkg::ST_TURN: begin
        // let the memory release the bus before anyone drives it
        if (cnt_q == 4'h1) begin
          st_d  = sram_host_pkg::ST_IDLE;
          rdy_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      sram_host_pkg::ST_WR_SETUP: begin
        // address stable before the write starts
        cs_n_d = 1'b0;
        ub_n_d = ~be_q[1];                   // only written lanes
        lb_n_d = ~be_q[0];
        dqoe_d = 1'b1;
        we_n_d = 1'b0;                       // select, strobe and lane selects low open the write
        cnt_d  = sram_host_pkg::WR_PULSE_CYC;
        st_d   = sram_host_pkg::ST_WR_PULSE;
      end
      sram_host_pkg::ST_WR_PULSE: begin
        // strobe width, address and data setup to the closing edge
        if (cnt_q == 4'h1) begin
          we_n_d = 1'b1;                     // strobe alone ends the write
          cnt_d  = sram_host_pkg::WR_RECOV_CYC;
          st_d   = sram_host_pkg::ST_WR_RECOV;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      sram_host_pkg::ST_WR_RECOV: begin
        // data and address held past the end, full cycle length met
        if (cnt_q == 4'h1) begin
          cs_n_d = 1'b1;
          ub_n_d = 1'b1;
          lb_n_d = 1'b1;
          dqoe_d = 1'b0;
          rdy_d  = 1'b1;
          st_d   = sram_host_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        st_d   = sram_host_pkg::ST_IDLE;
        cs_n_d = 1'b1;
        we_n_d = 1'b1;
        oe_n_d = 1'b1;
        ub_n_d = 1'b1;
        lb_n_d = 1'b1;
        dqoe_d = 1'b0;
        rdy_d  = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reset leaves the memory deselected and the bus released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= sram_host_pkg::ST_IDLE;
      cnt_q  <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      be_q   <= '0;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      lb_n_q <= 1'b1;
      dqoe_q <= 1'b0;
      rdy_q  <= 1'b1;
      rv_q   <= 1'b0;
      rdat_q <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      be_q   <= be_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      ub_n_q <= ub_n_d;
      lb_n_q <= lb_n_d;
      dqoe_q <= dqoe_d;
      rdy_q  <= rdy_d;
      rv_q   <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops
  // ---------------------------------------------------------------
  assign req_ready        = rdy_q;
  assign rsp_valid        = rv_q;
  assign rsp_rdata        = rdat_q;
  assign mem_addr         = addr_q;
  assign chip_sel_n       = cs_n_q;
  assign write_en_n       = we_n_q;
  assign out_en_n         = oe_n_q;
  assign upper_byte_sel_n = ub_n_q;
  assign lower_byte_sel_n = lb_n_q;
  assign mem_dq_o         = wdat_q;
  assign mem_dq_oe        = dqoe_q;

endmodule : sram_host

// ===== hdl/sram_host_pkg.sv
// constants and types shared by the static memory host controller
package sram_host_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BE_W   = 2;

  // ---------------------------------------------------------------
  // timing figures in ns and the clock period
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS          = 20;
  localparam int unsigned READ_CYCLE_MIN_NS      = 45;
  localparam int unsigned ADDR_ACCESS_MAX_NS     = 45;
  localparam int unsigned OUTPUT_DRIVE_ACCESS_NS = 22;
  localparam int unsigned WRITE_PULSE_WIDTH_NS   = 35;
  localparam int unsigned WRITE_ADDR_SETUP_END_NS = 35;
  localparam int unsigned BYTE_SEL_WRITE_WIDTH_NS = 35;
  localparam int unsigned WRITE_DATA_SETUP_NS    = 25;
  localparam int unsigned WRITE_CYCLE_MIN_NS     = 45;
  localparam int unsigned WRITE_DATA_HOLD_NS     = 0;
  localparam int unsigned DRIVE_TURN_NS          = 18;

  // least times round up, never below one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  function automatic int unsigned max2(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int unsigned CNT_W = 4;
  // read: wait for address access plus two cycles for the two-stage input synchroniser
  localparam logic [CNT_W-1:0] RD_CYC =
    CNT_W'(max2(ns_to_cyc(READ_CYCLE_MIN_NS), ns_to_cyc(ADDR_ACCESS_MAX_NS)) + 2);
  // write strobe low: covers pulse width, address, byte select and data setup
  localparam logic [CNT_W-1:0] WR_PULSE_CYC =
    CNT_W'(max2(max2(ns_to_cyc(WRITE_PULSE_WIDTH_NS), ns_to_cyc(WRITE_ADDR_SETUP_END_NS)),
                max2(ns_to_cyc(BYTE_SEL_WRITE_WIDTH_NS), ns_to_cyc(WRITE_DATA_SETUP_NS))));
  // recovery after the strobe so the whole cycle meets its minimum
  localparam logic [CNT_W-1:0] WR_RECOV_CYC =
    CNT_W'(max2(ns_to_cyc(WRITE_CYCLE_MIN_NS) - WR_PULSE_CYC, 1));
  // bus turnaround before the host drives after a read
  localparam logic [CNT_W-1:0] TURN_CYC = CNT_W'(ns_to_cyc(DRIVE_TURN_NS));

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_TURN,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_RECOV
  } host_state_t;

endpackage : sram_host_pkg

// ===== hdl/sram_bus_sync.sv
// two-stage synchroniser for the data pins read back from the memory
`timescale 1ns/1ns
module sram_bus_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : sram_bus_sync

// ===== sim/sram_mem_model.sv
// behavioural model of the 256K x 16 static memory on the far side
`timescale 1ns/1ns
module sram_mem_model #(
  parameter int ACC_NS = 45
) (
  input  wire logic        chip_sel_n,
  input  wire logic        write_en_n,
  input  wire logic        out_en_n,
  input  wire logic        upper_byte_sel_n,
  input  wire logic        lower_byte_sel_n,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic      [1:0]  dq_drv
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] wd;
  logic [15:0] old;
  logic [17:0] wa;
  logic [1:0]  wl;
  logic        win;
  logic        standby;
  // ---------------------------------------------------------------
  // write window
  // ---------------------------------------------------------------
  // open only while select, strobe and a lane select are all low
  assign win = !chip_sel_n && !write_en_n && !(upper_byte_sel_n && lower_byte_sel_n);
  assign standby = chip_sel_n;
  // follow the bus while open, so the closing edge keeps the last data
  always @(*) if (win) begin
    wd = dq_in;
    wa = addr;
    wl = {!upper_byte_sel_n, !lower_byte_sel_n};
  end
  // the unknown-to-low step at start-up carries no lanes and stores nothing
  always @(negedge win) begin
    if (wl != 2'b00) begin
      old = mem.exists(wa) ? mem[wa] : 16'h0000;
      if (wl[0]) old[7:0] = wd[7:0];
      if (wl[1]) old[15:8] = wd[15:8];
      mem[wa] = old;
    end
  end
  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  // lanes drive only in a read; floats while writing or deselected
  assign dq_drv = (!standby && write_en_n && !out_en_n) ?
                  {!upper_byte_sel_n, !lower_byte_sel_n} : 2'b00;
  initial dq_out = 16'h0000;
  // slowest legal answer: old word 10 ns, garbage, then new word
  always @(addr) begin
    dq_out <= #10 ~dq_out;
    dq_out <= #ACC_NS (mem.exists(addr) ? mem[addr] : 16'h0000);
  end
  always @(chip_sel_n, out_en_n, upper_byte_sel_n, lower_byte_sel_n)
    dq_out <= #(ACC_NS / 2) (mem.exists(addr) ? mem[addr] : 16'h0000);
endmodule : sram_mem_model

// ===== sim/sram_host_chk.sv
// pin timing assertions for the static memory host controller
`timescale 1ns/1ns
module sram_host_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [17:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [1:0]  req_be,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [17:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        write_en_n,
  input wire logic        out_en_n,
  input wire logic        upper_byte_sel_n,
  input wire logic        lower_byte_sel_n,
  input wire logic [15:0] mem_dq_o,
  input wire logic        mem_dq_oe
);
  logic tk_rd;
  logic tk_wr;
  // taken needs ready, valid and a nonzero lane mask
  assign tk_rd = req_valid && req_ready && req_be != 2'b00 && !req_write;
  assign tk_wr = req_valid && req_ready && req_be != 2'b00 && req_write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_walk;
    tk_rd |=> (!chip_sel_n && !out_en_n)[*5] ##1 (chip_sel_n && rsp_valid);
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("read cycle length wrong");
  property p_rd_addr;
    tk_rd |=> mem_addr == $past(req_addr) && upper_byte_sel_n == !$past(req_be[1])
              && lower_byte_sel_n == !$past(req_be[0]);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address late");
  property p_wr_walk;
    tk_wr |=> chip_sel_n ##1 (!chip_sel_n && !write_en_n && mem_dq_oe)[*2]
              ##1 (write_en_n && !chip_sel_n && mem_dq_oe) ##1 (chip_sel_n && !mem_dq_oe);
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write pulse timing wrong");
  property p_wr_data;
    tk_wr |=> ##1 mem_dq_o == $past(req_wdata, 2) && mem_addr == $past(req_addr, 2);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data wrong");
  property p_we_rd;
    !out_en_n |-> write_en_n;
  endproperty
  a_we_rd: assert property (p_we_rd) else $error("strobe low in read");
  property p_no_fight;
    mem_dq_oe |-> out_en_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both sides drive");
  property p_sel_idle;
    chip_sel_n |-> upper_byte_sel_n && lower_byte_sel_n;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("lane select while idle");
  property p_addr_hold;
    !write_en_n |=> $stable(mem_addr)
                    && (write_en_n || $stable({upper_byte_sel_n, lower_byte_sel_n}));
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("write moved pins");
endmodule : sram_host_chk
bind sram_host sram_host_chk sram_host_chk_inst (.*);

// ===== sim/tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        rst_n;
  logic        req_valid;
  logic        req_write;
  logic [17:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0]  req_be;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic [17:0] mem_addr;
  logic        chip_sel_n;
  logic        write_en_n;
  logic        out_en_n;
  logic        upper_byte_sel_n;
  logic        lower_byte_sel_n;
  logic [15:0] mem_dq_o;
  logic        mem_dq_oe;
  logic [15:0] mem_dq_i;
  logic [15:0] md;
  logic [1:0]  drv;
  logic [15:0] shadow [logic [17:0]];
  int          err_total;
  int          total_checks;
  sram_host sram_host_inst (.*);
  sram_mem_model sram_mem_model_inst (
    .chip_sel_n       (chip_sel_n),
    .write_en_n       (write_en_n),
    .out_en_n         (out_en_n),
    .upper_byte_sel_n (upper_byte_sel_n),
    .lower_byte_sel_n (lower_byte_sel_n),
    .addr             (mem_addr),
    .dq_in            (mem_dq_i),
    .dq_out           (md),
    .dq_drv           (drv)
  );
  // undriven lanes show the inverse, so a stale word never matches
  assign mem_dq_i[7:0]  = mem_dq_oe ? mem_dq_o[7:0] : (drv[0] ? md[7:0] : ~md[7:0]);
  assign mem_dq_i[15:8] = mem_dq_oe ? mem_dq_o[15:8] : (drv[1] ? md[15:8] : ~md[15:8]);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic bit chk(input bit miss);
    total_checks++;
    return miss;
  endfunction : chk
  task automatic bad(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : bad
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic send(input logic w, input logic [17:0] a, input logic [15:0] d,
                      input logic [1:0] be);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20) begin
        bad("ready never came");
        report_and_stop();
      end
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_be    <= be;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask : send
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] v;
    send(1'b1, a, d, be);
    v = shadow.exists(a) ? shadow[a] : 16'h0000;
    if (be[0]) v[7:0] = d[7:0];
    if (be[1]) v[15:8] = d[15:8];
    shadow[a] = v;
  endtask : wr
  // answer rises at the edge that ends the read count, for one cycle only
  task automatic rd(input logic [17:0] a, input logic [1:0] be);
    int n;
    send(1'b0, a, 16'h0000, be);
    for (n = 1; n <= 8 && rsp_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (chk(n != int'(sram_host_pkg::RD_CYC) + 1)) bad("read answer late or early");
    if (be[0]) if (chk(rsp_rdata[7:0] !== shadow[a][7:0])) bad("lower lane data");
    if (be[1]) if (chk(rsp_rdata[15:8] !== shadow[a][15:8])) bad("upper lane data");
    @(posedge clk);
    #1;
    if (chk(rsp_valid !== 1'b0)) bad("answer pulse too long");
  endtask : rd
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_words();
    wr(18'h00000, 16'ha55a, 2'b11);
    wr(18'h3ffff, 16'h1234, 2'b11);
    rd(18'h3ffff, 2'b11);
    rd(18'h00000, 2'b11);
  endtask : t_words
  // partial writes must leave the other lane alone
  task automatic t_lanes();
    int i;
    wr(18'h15a5a, 16'hffff, 2'b11);
    for (i = 1; i < 4; i++) begin
      wr(18'h15a5a, 16'h0f00 + 16'(i), 2'(i));
      rd(18'h15a5a, 2'b11);
      rd(18'h15a5a, 2'(i));
    end
  endtask : t_lanes
  task automatic t_refuse();
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_be    <= 2'b00;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      if (chk(chip_sel_n !== 1'b1 || req_ready !== 1'b1)) bad("empty mask taken");
    end
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask : t_refuse
  // reset in the middle of a write must release select, strobe, output enable and data drive at once
  task automatic t_reset();
    send(1'b1, 18'h2aaaa, 16'h5aa5, 2'b11);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    if (chk({chip_sel_n, write_en_n, out_en_n, mem_dq_oe} !== 4'he)) bad("pins idle");
    if (chk(req_ready !== 1'b1 || rsp_valid !== 1'b0)) bad("ready after reset");
    rd(18'h3ffff, 2'b11);
  endtask : t_reset
  initial begin
    err_total = 0;
    total_checks = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 18'h00000;
    req_wdata = 16'h0000;
    req_be = 2'b00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    if (chk({chip_sel_n, write_en_n, out_en_n, mem_dq_oe} !== 4'he)) bad("reset pins");
    t_words();
    t_lanes();
    t_refuse();
    t_reset();
    report_and_stop();
  end
endmodule : tb
